// file: rssu_pkg.sv
// shared types and constants of the rotate, shift and subtract unit
package rssu_pkg;

  // ==========================================================
  // widths and field positions
  localparam int DATA_W = 16;
  localparam int LIT_W = 14;
  localparam int IDX_W = 4;
  localparam int PROG_W = 24;
  localparam int AMT_W = 5;
  localparam int LIT10_W = 10;
  localparam int LIT5_W = 5;
  localparam int PROG_HI_MSB = 23;
  localparam int PROG_HI_LSB = 16;
  localparam int BYTE_W = 8;
  localparam int SIGN_BYTE_BIT = 7;
  localparam int NIBBLE_W = 4;
  localparam logic [IDX_W-1:0] DEFAULT_WORK_REG = 4'h0;

  // ==========================================================
  // timing counts, in cycles of clk_sys
  localparam int RET_CYCLES = 3;
  localparam int RET_SHORT_CYCLES = 2;
  localparam int TBL_CYCLES = 2;
  localparam logic [1:0] RET_WAIT = 2'(RET_CYCLES - 2);
  localparam logic [1:0] RET_SHORT_WAIT = 2'(RET_SHORT_CYCLES - 2);
  localparam logic [1:0] TBL_WAIT = 2'(TBL_CYCLES - 2);

  // ==========================================================
  // operations issued by the decoder
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_REPEAT_LIT = 5'h01,
    OP_REPEAT_REG = 5'h02,
    OP_RETURN_LIT = 5'h03,
    OP_ROTL_C = 5'h04,
    OP_ROTL = 5'h05,
    OP_ROTR_C = 5'h06,
    OP_ROTR = 5'h07,
    OP_SIGN_EXT = 5'h08,
    OP_SHL1 = 5'h09,
    OP_SHL_REG = 5'h0a,
    OP_SHL_LIT = 5'h0b,
    OP_BSUB_REG = 5'h0c,
    OP_BSUB_L10 = 5'h0d,
    OP_BSUB_L5 = 5'h0e,
    OP_RBSUB_REG = 5'h0f,
    OP_RBSUB_L5 = 5'h10,
    OP_TBL_UPPER = 5'h11
  } rssu_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RET = 3'b010,
    ST_TBL = 3'b100
  } rssu_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    rssu_op_t op;
    logic [DATA_W-1:0] base;
    logic [DATA_W-1:0] src;
    logic [LIT_W-1:0] lit;
    logic [IDX_W-1:0] dst;
    logic to_default_work_reg;
    logic short_ret;
  } rssu_req_t;

  typedef struct packed {
    logic wr;
    logic low_only;
    logic [IDX_W-1:0] dst;
    logic [DATA_W-1:0] data;
  } rssu_res_t;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic negative;
    logic overflow;
    logic zero;
  } rssu_flags_t;

  localparam rssu_flags_t FLAGS_RESET = 5'h00;

endpackage : rssu_pkg

// file: rssu_sub_unit.sv
// borrow subtractor: minuend - subtrahend - not carry
`timescale 1ns/1ps
module rssu_sub_unit (
  input wire logic [rssu_pkg::DATA_W-1:0] minuend,
  input wire logic [rssu_pkg::DATA_W-1:0] subtrahend,
  input wire logic carry_in,
  output logic [rssu_pkg::DATA_W-1:0] diff,
  output logic carry_out,
  output logic digit_carry,
  output logic overflow
);
  import rssu_pkg::*;

  logic [DATA_W:0] full;
  logic [NIBBLE_W:0] low;

  // ==========================================================
  // add the complement: carry out high means no borrow
  assign full = {1'b0, minuend} + {1'b0, ~subtrahend} + (DATA_W+1)'(carry_in);
  assign low = {1'b0, minuend[NIBBLE_W-1:0]}
             + {1'b0, ~subtrahend[NIBBLE_W-1:0]} + (NIBBLE_W+1)'(carry_in);
  assign diff = full[DATA_W-1:0];
  assign carry_out = full[DATA_W];
  assign digit_carry = low[NIBBLE_W];
  assign overflow = (minuend[DATA_W-1] ^ subtrahend[DATA_W-1])
                  & (full[DATA_W-1] ^ minuend[DATA_W-1]);

endmodule : rssu_sub_unit

// file: rssu_shift_unit.sv
// rotates, sign extension and left shifts
`timescale 1ns/1ps
module rssu_shift_unit (
  input wire rssu_pkg::rssu_op_t op,
  input wire logic [rssu_pkg::DATA_W-1:0] value,
  input wire logic [rssu_pkg::AMT_W-1:0] amount,
  input wire logic carry_in,
  output logic [rssu_pkg::DATA_W-1:0] shifted,
  output logic carry_out,
  output logic overflow
);
  import rssu_pkg::*;

  // ==========================================================
  // one-place moves and the barrel shift
  always_comb begin
    shifted = value;
    carry_out = carry_in;
    overflow = 1'b0;
    case (op)
      OP_ROTL_C: begin
        shifted = {value[DATA_W-2:0], carry_in};
        carry_out = value[DATA_W-1];
      end
      OP_ROTL: shifted = {value[DATA_W-2:0], value[DATA_W-1]};
      OP_ROTR_C: begin
        shifted = {carry_in, value[DATA_W-1:1]};
        carry_out = value[0];
      end
      OP_ROTR: shifted = {value[0], value[DATA_W-1:1]};
      OP_SIGN_EXT: begin
        shifted = {{BYTE_W{value[SIGN_BYTE_BIT]}}, value[BYTE_W-1:0]};
        carry_out = ~value[SIGN_BYTE_BIT];
      end
      OP_SHL1: begin
        shifted = {value[DATA_W-2:0], 1'b0};
        carry_out = value[DATA_W-1];
        overflow = value[DATA_W-1] ^ value[DATA_W-2];
      end
      // amounts of sixteen or more clear the word
      OP_SHL_REG, OP_SHL_LIT: shifted = value << amount;
      default: shifted = value;
    endcase
  end

endmodule : rssu_shift_unit

// file: rssu_core.sv
// rotate, shift and subtract execution unit with repeat and table read
`timescale 1ns/1ps
module rssu_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire rssu_pkg::rssu_req_t req,
  output logic req_ready,
  output rssu_pkg::rssu_res_t res,
  output rssu_pkg::rssu_flags_t flags,
  output logic rpt_hold,
  output logic [rssu_pkg::LIT_W-1:0] rpt_count,
  output logic prog_rd,
  output logic [rssu_pkg::DATA_W-1:0] prog_addr,
  input wire logic [rssu_pkg::PROG_W-1:0] prog_data,
  output logic ret_pop
);
  import rssu_pkg::*;

  // ==========================================================
  // decode helpers
  function automatic logic is_sub(input rssu_op_t op);
    is_sub = (op == OP_BSUB_REG) || (op == OP_BSUB_L10)
          || (op == OP_BSUB_L5) || (op == OP_RBSUB_REG)
          || (op == OP_RBSUB_L5);
  endfunction : is_sub

  function automatic logic is_repeat(input rssu_op_t op);
    is_repeat = (op == OP_REPEAT_LIT) || (op == OP_REPEAT_REG);
  endfunction : is_repeat

  function automatic logic is_single(input rssu_op_t op);
    is_single = is_sub(op) || ((op >= OP_ROTL_C) && (op <= OP_SHL_LIT));
  endfunction : is_single

  // which flags an operation may change
  function automatic rssu_flags_t flag_mask(input rssu_op_t op);
    flag_mask = 5'h00;
    case (op)
      OP_ROTL_C, OP_ROTR_C, OP_SIGN_EXT: flag_mask = 5'h15;
      OP_ROTL, OP_ROTR: flag_mask = 5'h05;
      OP_SHL1: flag_mask = 5'h17;
      OP_SHL_REG, OP_SHL_LIT: flag_mask = 5'h05;
      default: flag_mask = is_sub(op) ? 5'h1f : 5'h00;
    endcase
  endfunction : flag_mask

  // ==========================================================
  // datapath
  logic take;
  rssu_state_t state;
  logic [1:0] wait_left;
  logic [IDX_W-1:0] held_dst;
  logic [LIT10_W-1:0] held_lit;
  logic [DATA_W-1:0] sh_in;
  logic [AMT_W-1:0] sh_amt;
  logic [DATA_W-1:0] sh_out;
  logic sh_carry;
  logic sh_ovf;
  logic [DATA_W-1:0] sub_a;
  logic [DATA_W-1:0] sub_b;
  logic [DATA_W-1:0] sub_out;
  logic sub_carry;
  logic sub_dcarry;
  logic sub_ovf;
  logic [DATA_W-1:0] next_data;
  logic [IDX_W-1:0] next_dst;
  rssu_flags_t next_flags;
  rssu_flags_t mask;

  assign take = req_valid && req_ready;

  always_comb begin
    sh_in = req.src;
    sh_amt = req.lit[AMT_W-1:0];
    case (req.op)
      OP_SHL_REG: begin
        sh_in = req.base;
        sh_amt = req.src[AMT_W-1:0];
      end
      OP_SHL_LIT: sh_in = req.base;
      default: sh_in = req.src;
    endcase
  end

  always_comb begin
    sub_a = req.base;
    sub_b = req.src;
    case (req.op)
      OP_BSUB_L10: sub_b = DATA_W'(req.lit[LIT10_W-1:0]);
      OP_BSUB_L5: sub_b = DATA_W'(req.lit[LIT5_W-1:0]);
      OP_RBSUB_REG: begin
        sub_a = req.src;
        sub_b = req.base;
      end
      OP_RBSUB_L5: begin
        sub_a = DATA_W'(req.lit[LIT5_W-1:0]);
        sub_b = req.base;
      end
      default: sub_b = req.src;
    endcase
  end

  rssu_shift_unit u_shift (
    .op(req.op),
    .value(sh_in),
    .amount(sh_amt),
    .carry_in(flags.carry),
    .shifted(sh_out),
    .carry_out(sh_carry),
    .overflow(sh_ovf)
  );

  rssu_sub_unit u_sub (
    .minuend(sub_a),
    .subtrahend(sub_b),
    .carry_in(flags.carry),
    .diff(sub_out),
    .carry_out(sub_carry),
    .digit_carry(sub_dcarry),
    .overflow(sub_ovf)
  );

  always_comb begin
    mask = flag_mask(req.op);
    next_data = is_sub(req.op) ? sub_out : sh_out;
    // to_default_work_reg sends the result to DEFAULT_WORK_REG instead of dst
    next_dst = req.to_default_work_reg ? DEFAULT_WORK_REG : req.dst;
    next_flags.carry = is_sub(req.op) ? sub_carry : sh_carry;
    next_flags.digit_carry = sub_dcarry;
    next_flags.negative = next_data[DATA_W-1];
    next_flags.overflow = is_sub(req.op) ? sub_ovf : sh_ovf;
    next_flags.zero = (next_data == '0);
  end

  // ==========================================================
  // sequencer for the multi-cycle operations
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      wait_left <= 2'h0;
      req_ready <= 1'b1;
      held_dst <= '0;
      held_lit <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take && req.op == OP_RETURN_LIT) begin
            state <= ST_RET;
            wait_left <= req.short_ret ? RET_SHORT_WAIT : RET_WAIT;
            req_ready <= 1'b0;
            held_dst <= req.dst;
            held_lit <= req.lit[LIT10_W-1:0];
          end else if (take && req.op == OP_TBL_UPPER) begin
            state <= ST_TBL;
            wait_left <= TBL_WAIT;
            req_ready <= 1'b0;
            held_dst <= req.dst;
          end
        end
        ST_RET, ST_TBL: begin
          if (wait_left == 2'h0) begin
            state <= ST_IDLE;
            req_ready <= 1'b1;
          end else begin
            wait_left <= wait_left - 2'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // result write port, one-cycle strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      res <= '0;
      ret_pop <= 1'b0;
    end else begin
      res.wr <= 1'b0;
      res.low_only <= 1'b0;
      ret_pop <= 1'b0;
      if (take && is_single(req.op)) begin
        res.wr <= 1'b1;
        res.dst <= next_dst;
        res.data <= next_data;
      end else if (state == ST_RET && wait_left == 2'h0) begin
        res.wr <= 1'b1;
        res.dst <= held_dst;
        res.data <= DATA_W'(held_lit);
        ret_pop <= 1'b1;
      end else if (state == ST_TBL && wait_left == 2'h0) begin
        res.wr <= 1'b1;
        res.low_only <= 1'b1;
        res.dst <= held_dst;
        res.data <= DATA_W'(prog_data[PROG_HI_MSB:PROG_HI_LSB]);
      end
    end
  end

  // ==========================================================
  // program memory read, address held until the next read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prog_rd <= 1'b0;
      prog_addr <= '0;
    end else begin
      prog_rd <= take && req.op == OP_TBL_UPPER;
      if (take && req.op == OP_TBL_UPPER) begin
        prog_addr <= req.src;
      end
    end
  end

  // ==========================================================
  // status flags: only masked bits move
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else if (take && is_single(req.op)) begin
      flags <= (flags & ~mask) | (next_flags & mask);
    end
  end

  // ==========================================================
  // repeat counter; the decoder reissues while rpt_hold is high
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rpt_count <= '0;
      rpt_hold <= 1'b0;
    end else if (take && req.op == OP_REPEAT_LIT) begin
      rpt_count <= req.lit;
      rpt_hold <= (req.lit != '0);
    end else if (take && req.op == OP_REPEAT_REG) begin
      rpt_count <= req.src[LIT_W-1:0];
      rpt_hold <= (req.src[LIT_W-1:0] != '0);
    end else if (take && rpt_count != '0) begin
      // a repeat nested in a repeat would restart the count instead
      rpt_count <= rpt_count - LIT_W'(1);
      rpt_hold <= (rpt_count != LIT_W'(1));
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_ret_long;
    take && req.op == OP_RETURN_LIT && !req.short_ret;
  endsequence

  sequence s_ret_short;
    take && req.op == OP_RETURN_LIT && req.short_ret;
  endsequence

  sequence s_tbl;
    take && req.op == OP_TBL_UPPER;
  endsequence

  AST_REPEAT_LIT: assert property (
    take && req.op == OP_REPEAT_LIT |=>
      rpt_count == $past(req.lit) && flags == $past(flags) && !res.wr)
    else $error("literal repeat count not loaded");

  AST_REPEAT_REG: assert property (
    take && req.op == OP_REPEAT_REG |=>
      rpt_count == $past(req.src[LIT_W-1:0]) && $stable(flags))
    else $error("register repeat count wrong or flags moved");

  AST_RET_LONG: assert property (
    s_ret_long |=> !res.wr && !req_ready ##1 !res.wr
      ##1 res.wr && ret_pop && res.data == DATA_W'($past(held_lit)))
    else $error("long literal return timing wrong");

  AST_RET_SHORT: assert property (
    s_ret_short |=> !res.wr ##1 res.wr && ret_pop && req_ready)
    else $error("short literal return timing wrong");

  AST_TBL: assert property (
    s_tbl |=> prog_rd && $stable(flags) ##1 res.wr && res.low_only
      && res.data == DATA_W'($past(prog_data[PROG_HI_MSB:PROG_HI_LSB])))
    else $error("upper table read wrong");

  AST_ROTL_C: assert property (
    take && req.op == OP_ROTL_C |=>
      res.data == {$past(req.src[DATA_W-2:0]), $past(flags.carry)}
      && flags.carry == $past(req.src[DATA_W-1]))
    else $error("rotate left through carry wrong");

  AST_ROTR_PLAIN: assert property (
    take && req.op == OP_ROTR |=>
      res.data[DATA_W-1] == $past(req.src[0]) && $stable(flags.carry))
    else $error("plain rotate right moved carry");

  AST_SIGN_EXT: assert property (
    take && req.op == OP_SIGN_EXT |=>
      res.data[DATA_W-1:BYTE_W] == {BYTE_W{$past(req.src[SIGN_BYTE_BIT])}})
    else $error("sign extension wrong");

  AST_SHL_REG: assert property (
    take && req.op == OP_SHL_REG |=>
      $stable(flags.carry) && $stable(flags.overflow) && res.wr)
    else $error("register shift moved carry or overflow");

  AST_SUB_FLAGS: assert property (
    take && is_sub(req.op) |=>
      flags.zero == (res.data == '0) && flags.negative == res.data[DATA_W-1])
    else $error("subtract zero or negative flag wrong");

endmodule : rssu_core

// file: rssu_partner.sv
// program memory and register file model standing beside the unit
`timescale 1ns/1ps
module rssu_partner (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic prog_rd,
  input wire logic [rssu_pkg::DATA_W-1:0] prog_addr,
  output logic [rssu_pkg::PROG_W-1:0] prog_data,
  input wire rssu_pkg::rssu_res_t res,
  input wire logic [rssu_pkg::IDX_W-1:0] rd_idx,
  output logic [rssu_pkg::DATA_W-1:0] rd_val
);
  import rssu_pkg::*;
  logic [PROG_W-1:0] last;
  logic [DATA_W-1:0] regs [16];

  // ==========================================================
  // program memory
  // upper byte is scrambled from the address so each word differs
  function automatic logic [PROG_W-1:0] word(logic [DATA_W-1:0] a);
    return {a[7:0] ^ 8'ha5, a};
  endfunction : word

  // off the read cycle the bus shows the inverse of the last word,
  // so a sample taken a cycle late cannot match by chance
  assign prog_data = prog_rd ? word(prog_addr) : ~last;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last <= '0;
    end else if (prog_rd) begin
      last <= word(prog_addr);
    end
  end

  // ==========================================================
  // register file write port
  always_ff @(posedge clk_sys) begin
    if (res.wr) begin
      regs[res.dst] <= res.low_only ? {8'h00, res.data[7:0]} : res.data;
    end
  end

  assign rd_val = regs[rd_idx];
endmodule : rssu_partner

// file: test_rotate_shift_subtract_unit.sv
// self-checking testbench of the rotate, shift and subtract unit
`timescale 1ns/1ps
module test_rotate_shift_subtract_unit;
  import rssu_pkg::*;
  logic clk_sys, rst, req_valid, req_ready, rpt_hold, prog_rd, ret_pop;
  rssu_req_t req;
  rssu_res_t res;
  rssu_flags_t flags, ef;
  logic [LIT_W-1:0] rpt_count;
  logic [DATA_W-1:0] prog_addr, rd_val;
  logic [PROG_W-1:0] prog_data;
  logic [IDX_W-1:0] rd_idx;
  int n_fail, comparisons;

  rssu_core uut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .res(res), .flags(flags),
    .rpt_hold(rpt_hold), .rpt_count(rpt_count), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .prog_data(prog_data), .ret_pop(ret_pop));

  rssu_partner pm (.clk_sys(clk_sys), .rst(rst), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .prog_data(prog_data), .res(res),
    .rd_idx(rd_idx), .rd_val(rd_val));

  // ==========================================================
  // compare and drive helpers
  task automatic chk_val(logic [23:0] got, logic [23:0] exp, string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_flags(rssu_flags_t exp);
    comparisons++;
    if (flags !== exp) begin
      n_fail++;
      $display("wrong value at %0t: flags got %b want %b", $time, flags, exp);
    end
  endtask : chk_flags

  // returns at the falling edge of cycle 1 after the take edge
  task automatic issue(rssu_op_t op, logic [15:0] b, logic [15:0] s,
                       logic [13:0] l, logic [3:0] d, logic w, logic sr);
    @(negedge clk_sys);
    while (req_ready !== 1'b1) @(negedge clk_sys);
    req = '{op, b, s, l, d, w, sr};
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask : issue

  task automatic exec(rssu_op_t op, logic [15:0] b, logic [15:0] s,
                      logic [13:0] l, logic [3:0] d, logic w,
                      logic [15:0] ed, logic [3:0] edst, rssu_flags_t f);
    issue(op, b, s, l, d, w, 1'b0);
    chk_val(24'(res.wr), 24'h1, "write strobe");
    chk_val(24'(res.data), 24'(ed), "result");
    chk_val(24'(res.dst), 24'(edst), "destination");
    chk_flags(f);
    ef = f;
  endtask : exec

  // {difference, carry, digit carry, negative, overflow, zero}
  function automatic logic [20:0] sub_exp(logic [15:0] a, logic [15:0] b,
                                          logic c);
    logic [16:0] d;
    logic [4:0] lo;
    d = {1'b0, a} - {1'b0, b} - 17'(!c);
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(!c);
    return {d[15:0], !d[16], !lo[4], d[15],
            (a[15] != b[15]) && (d[15] != a[15]), d[15:0] == 16'h0000};
  endfunction : sub_exp

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk_val(24'(req_ready), 24'h1, "ready after reset");
    chk_val(24'(res), 24'h0, "result after reset");
    chk_val(24'(rpt_count), 24'h0, "repeat count after reset");
    chk_flags(FLAGS_RESET);
    $display("test reset finished");
  endtask : t_reset

  task automatic t_rotate();
    exec(OP_ROTR_C, 16'h0, 16'h0001, 14'h0, 4'h1, 1'b0,
         16'h0000, 4'h1, 5'h11);
    exec(OP_ROTR, 16'h0, 16'h0001, 14'h0, 4'h2, 1'b0,
         16'h8000, 4'h2, 5'h14);
    exec(OP_ROTL_C, 16'h0, 16'h4000, 14'h0, 4'h3, 1'b0,
         16'h8001, 4'h3, 5'h04);
    exec(OP_ROTL, 16'h0, 16'h8000, 14'h0, 4'h4, 1'b0,
         16'h0001, 4'h4, 5'h00);
    $display("test rotate finished");
  endtask : t_rotate

  task automatic t_shift();
    exec(OP_SIGN_EXT, 16'h0, 16'h0080, 14'h0, 4'h5, 1'b0,
         16'hff80, 4'h5, 5'h04);
    exec(OP_SIGN_EXT, 16'h0, 16'h127f, 14'h0, 4'h6, 1'b0,
         16'h007f, 4'h6, 5'h10);
    exec(OP_SHL1, 16'h0, 16'h4001, 14'h0, 4'h5, 1'b1,
         16'h8002, 4'h0, 5'h06);
    exec(OP_SHL_LIT, 16'h0001, 16'h0, 14'h0010, 4'h7, 1'b0,
         16'h0, 4'h7, 5'h03);
    exec(OP_SHL_REG, 16'h0f0f, 16'hffe4, 14'h0, 4'h8, 1'b0,
         16'hf0f0, 4'h8, 5'h06);
    $display("test shift finished");
  endtask : t_shift

  task automatic t_sub(rssu_op_t op, logic [15:0] b, logic [15:0] s,
                       logic [13:0] l);
    logic [15:0] m;
    logic [15:0] n;
    logic [20:0] x;
    case (op)
      OP_BSUB_REG: {m, n} = {b, s};
      OP_BSUB_L10: {m, n} = {b, 16'(l[9:0])};
      OP_BSUB_L5: {m, n} = {b, 16'(l[4:0])};
      OP_RBSUB_REG: {m, n} = {s, b};
      default: {m, n} = {16'(l[4:0]), b};
    endcase
    x = sub_exp(m, n, ef.carry);
    exec(op, b, s, l, 4'h9, 1'b0, x[20:5], 4'h9, x[4:0]);
  endtask : t_sub

  task automatic t_ret(logic sr);
    issue(OP_RETURN_LIT, 16'h0, 16'h0, 14'h3abc, 4'ha, 1'b0, sr);
    chk_val(24'(req_ready), 24'h0, "ready while returning");
    if (!sr) begin
      @(negedge clk_sys);
      chk_val(24'(ret_pop), 24'h0, "early return pop");
    end
    @(negedge clk_sys);
    chk_val(24'({res.wr, ret_pop, req_ready}), 24'h7, "return end");
    chk_val(24'(res.data), 24'h0002bc, "return literal");
    chk_flags(ef);
    $display("test return finished");
  endtask : t_ret

  task automatic t_table();
    rd_idx = 4'h7;
    issue(OP_TBL_UPPER, 16'h0, 16'h1234, 14'h0, 4'h7, 1'b0, 1'b0);
    chk_val(24'({prog_rd, req_ready}), 24'h2, "table read strobe");
    chk_val(24'(prog_addr), 24'h1234, "table address");
    @(negedge clk_sys);
    chk_val(24'({res.wr, res.low_only}), 24'h3, "table write");
    chk_val(24'(res.data), 24'h000091, "table upper byte");
    chk_flags(ef);
    @(negedge clk_sys);
    chk_val(24'(rd_val), 24'h000091, "register file");
    $display("test table finished");
  endtask : t_table

  task automatic t_repeat();
    issue(OP_REPEAT_LIT, 16'h0, 16'h0, 14'h0002, 4'h0, 1'b0, 1'b0);
    chk_val(24'({res.wr, rpt_hold, rpt_count}), 24'h4002, "lit load");
    issue(OP_NOP, 16'h0, 16'h0, 14'h0, 4'h0, 1'b0, 1'b0);
    chk_val(24'({rpt_hold, rpt_count}), 24'h4001, "first rerun");
    issue(OP_NOP, 16'h0, 16'h0, 14'h0, 4'h0, 1'b0, 1'b0);
    chk_val(24'({rpt_hold, rpt_count}), 24'h0, "last rerun");
    issue(OP_REPEAT_REG, 16'h0, 16'hc005, 14'h0, 4'h0, 1'b0, 1'b0);
    chk_val(24'({res.wr, rpt_count}), 24'h0005, "reg load");
    chk_flags(ef);
    issue(OP_REPEAT_LIT, 16'h0, 16'h0, 14'h3fff, 4'h0, 1'b0, 1'b0);
    chk_val(24'(rpt_count), 24'h3fff, "largest count");
    issue(OP_NOP, 16'h0, 16'h0, 14'h0, 4'h0, 1'b0, 1'b0);
    chk_val(24'(rpt_count), 24'h3ffe, "count down");
    $display("test repeat finished");
  endtask : t_repeat

  // ==========================================================
  // clock, run and verdict
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // all tests need well under 200 cycles
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_fail++;
    results();
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    rd_idx = 4'h0;
    ef = FLAGS_RESET;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_rotate();
    t_shift();
    t_sub(OP_BSUB_REG, 16'h0005, 16'h0006, 14'h0);
    t_sub(OP_BSUB_L10, 16'h8000, 16'h0, 14'h3c01);
    t_sub(OP_BSUB_L5, 16'h0010, 16'h0, 14'h0031);
    t_sub(OP_RBSUB_REG, 16'h0001, 16'h0001, 14'h0);
    t_sub(OP_RBSUB_L5, 16'h0003, 16'h0, 14'h0003);
    $display("test subtract finished");
    t_ret(1'b0);
    t_ret(1'b1);
    t_table();
    t_repeat();
    results();
  end
endmodule : test_rotate_shift_subtract_unit
